// *** rtl/dual_joystick_port.sv ***
`timescale 1ns/1ns
module dual_joystick_port
    import stick_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        srst,
    // Decoded I/O cycles from the bus front end
    input  wire logic [15:0] io_addr,
    input  wire logic        io_rd_strobe,
    input  wire logic        io_wr_strobe,
    output logic [7:0]       io_rdata_r,
    output logic             io_rd_hit_r,
    // Configuration space port
    input  wire logic [7:0]  cfg_ldn,
    input  wire logic [7:0]  cfg_index,
    input  wire logic [7:0]  cfg_wdata,
    input  wire logic        cfg_wr,
    input  wire logic        cfg_rd,
    output logic [7:0]       cfg_rdata_r,
    output logic             cfg_rd_hit_r,
    // Buttons, sampled as given
    input  wire logic        stick1_button1,
    input  wire logic        stick1_button2,
    input  wire logic        stick2_button1,
    input  wire logic        stick2_button2,
    // Axis comparators and discharge drives: 0 s1x, 1 s1y, 2 s2x, 3 s2y
    input  wire logic [3:0]  rc_cmp_in,
    output logic [3:0]       rc_discharge,
    output logic             stick_active_r
);

    logic [7:0]  base_high_r;
    logic [7:0]  base_low_r;
    logic [3:0]  timer_bits;
    logic        restart_pulse;
    logic [7:0]  cfg_rdata_nxt;

    wire  [15:0] base_addr  = {base_high_r, base_low_r};
    wire  [15:0] state_addr = base_addr + STATE_OFFSET;
    wire         addr_match = (io_addr == state_addr);

    // Decode gated by the shared activate setting
    wire         rd_hit = io_rd_strobe & stick_active_r & addr_match;
    wire         wr_hit = io_wr_strobe & stick_active_r & addr_match;

    wire         ldn_sel      = (cfg_ldn == STICK_LDN);
    wire         wr_base_high = cfg_wr & ldn_sel & (cfg_index == BASE_HIGH_INDEX);
    wire         wr_base_low  = cfg_wr & ldn_sel & (cfg_index == BASE_LOW_INDEX);
    wire         wr_activate  = cfg_wr & ldn_sel & (cfg_index == ACTIVATE_INDEX);
    wire         wr_power     = cfg_wr & (cfg_index == POWER_CTRL_INDEX);

    wire         rd_base_high = cfg_rd & ldn_sel & (cfg_index == BASE_HIGH_INDEX);
    wire         rd_base_low  = cfg_rd & ldn_sel & (cfg_index == BASE_LOW_INDEX);
    wire         rd_activate  = cfg_rd & ldn_sel & (cfg_index == ACTIVATE_INDEX);
    wire         rd_power     = cfg_rd & (cfg_index == POWER_CTRL_INDEX);
    wire         cfg_hit      = rd_base_high | rd_base_low | rd_activate | rd_power;

    // Written data is dropped; only the strobe matters
    wire  [7:0]  state_byte = {stick2_button2, stick2_button1,
                               stick1_button2, stick1_button1,
                               timer_bits};

    always_comb begin
        cfg_rdata_nxt = CFG_IDLE_DATA;
        if (rd_base_high) begin
            cfg_rdata_nxt = base_high_r;
        end else if (rd_base_low) begin
            cfg_rdata_nxt = base_low_r;
        end else if (rd_activate) begin
            cfg_rdata_nxt[ACTIVATE_BIT] = stick_active_r;
        end else if (rd_power) begin
            // Other bits of this index belong to other functions
            cfg_rdata_nxt[POWER_BIT] = stick_active_r;
        end
    end

    // Restart fires on the back edge of the write strobe
    trail_edge u_wr_edge (
        .ref_clk (ref_clk),
        .srst    (srst),
        .level   (wr_hit),
        .pulse_r (restart_pulse)
    );

    genvar g;
    generate
        for (g = 0; g < AXIS_COUNT; g++) begin : g_axis
            axis_timer u_axis (
                .ref_clk        (ref_clk),
                .srst           (srst),
                .restart_hold   (wr_hit),
                .restart        (restart_pulse),
                .rc_cmp_in      (rc_cmp_in[g]),
                .timer_bit_r    (timer_bits[g]),
                .rc_discharge_r (rc_discharge[g])
            );
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            base_high_r <= BASE_RESET;
            base_low_r  <= BASE_RESET;
        end else begin
            if (wr_base_high) begin
                base_high_r <= cfg_wdata;
            end
            if (wr_base_low) begin
                base_low_r <= cfg_wdata;
            end
        end
    end

    // One flop behind both views; power index write wins on a tie
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            stick_active_r <= ACTIVE_RESET;
        end else if (wr_power) begin
            stick_active_r <= cfg_wdata[POWER_BIT];
        end else if (wr_activate) begin
            stick_active_r <= cfg_wdata[ACTIVATE_BIT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            io_rdata_r  <= STATE_RESET;
            io_rd_hit_r <= 1'b0;
        end else begin
            io_rdata_r  <= rd_hit ? state_byte : STATE_RESET;
            io_rd_hit_r <= rd_hit;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cfg_rdata_r  <= CFG_IDLE_DATA;
            cfg_rd_hit_r <= 1'b0;
        end else begin
            cfg_rdata_r  <= cfg_rdata_nxt;
            cfg_rd_hit_r <= cfg_hit;
        end
    end

endmodule : dual_joystick_port

// *** pkg/stick_pkg.sv ***
package stick_pkg;

    // Configuration space indices and logical device number
    localparam logic [7:0]  BASE_HIGH_INDEX  = 8'h60;
    localparam logic [7:0]  BASE_LOW_INDEX   = 8'h61;
    localparam logic [7:0]  ACTIVATE_INDEX   = 8'h30;
    localparam logic [7:0]  POWER_CTRL_INDEX = 8'h22;
    localparam logic [7:0]  STICK_LDN        = 8'h09;

    // I/O space offset of the state byte from the programmed base
    localparam logic [15:0] STATE_OFFSET     = 16'h0000;

    // Reset values
    localparam logic [7:0]  STATE_RESET      = 8'h00;
    localparam logic [7:0]  BASE_RESET       = 8'h00;
    localparam logic        ACTIVE_RESET     = 1'b0;
    localparam logic [7:0]  CFG_IDLE_DATA    = 8'h00;

    // Field positions and axis count
    localparam int          POWER_BIT        = 2;
    localparam int          ACTIVATE_BIT     = 0;
    localparam int          AXIS_COUNT       = 4;
    localparam int          BUTTON_LSB       = 4;
    localparam int          TIMER_LSB        = 0;

    typedef enum logic [0:0] {
        AXIS_IDLE   = 1'b0,
        AXIS_TIMING = 1'b1
    } axis_state_t;

endpackage : stick_pkg

// *** rtl/trail_edge.sv ***
`timescale 1ns/1ns
module trail_edge (
    input  wire logic ref_clk,
    input  wire logic srst,
    input  wire logic level,
    output logic      pulse_r
);

    logic prev_r;
    wire  fall = prev_r & ~level;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            prev_r  <= 1'b0;
            pulse_r <= 1'b0;
        end else begin
            prev_r  <= level;
            pulse_r <= fall;
        end
    end

endmodule : trail_edge

// *** rtl/axis_timer.sv ***
`timescale 1ns/1ns
module axis_timer
    import stick_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic srst,
    input  wire logic restart_hold,
    input  wire logic restart,
    input  wire logic rc_cmp_in,
    output logic      timer_bit_r,
    output logic      rc_discharge_r
);

    axis_state_t state_r;
    axis_state_t state_nxt;
    logic        discharge_nxt;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            AXIS_IDLE: begin
                if (restart) begin
                    state_nxt = AXIS_TIMING;
                end
            end
            AXIS_TIMING: begin
                // Comparator ignored while a new write is in flight
                if (!restart && !restart_hold && rc_cmp_in) begin
                    state_nxt = AXIS_IDLE;
                end
            end
            default: begin
                state_nxt = AXIS_IDLE;
            end
        endcase
    end

    // Pin held at zero while idle and during a write strobe that hits the state byte while active
    assign discharge_nxt = restart_hold | (state_nxt == AXIS_IDLE);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_r        <= AXIS_IDLE;
            timer_bit_r    <= 1'b0;
            rc_discharge_r <= 1'b1;
        end else begin
            state_r        <= state_nxt;
            timer_bit_r    <= (state_nxt == AXIS_TIMING);
            rc_discharge_r <= discharge_nxt;
        end
    end

endmodule : axis_timer

// *** tb/dual_joystick_port_asserts.sv ***
`timescale 1ns/1ns
module dual_joystick_port_asserts (
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic [15:0] io_addr,
    input  wire logic        io_rd_strobe,
    input  wire logic        io_wr_strobe,
    input  wire logic [7:0]  io_rdata_r,
    input  wire logic        io_rd_hit_r,
    input  wire logic [7:0]  cfg_ldn,
    input  wire logic [7:0]  cfg_index,
    input  wire logic [7:0]  cfg_wdata,
    input  wire logic        cfg_wr,
    input  wire logic [3:0]  rc_cmp_in,
    input  wire logic [3:0]  rc_discharge,
    input  wire logic        stick_active_r
);
    logic [15:0] base_r;
    wire         rd_hit = io_rd_strobe && stick_active_r && io_addr == base_r;
    wire         wr_hit = io_wr_strobe && stick_active_r && io_addr == base_r;
    // Shadow of the base, so hits can be judged from the ports alone
    always_ff @(posedge ref_clk) begin
        if (srst)
            base_r <= 16'h0000;
        else if (cfg_wr && cfg_ldn == 8'h09 && cfg_index == 8'h60)
            base_r[15:8] <= cfg_wdata;
        else if (cfg_wr && cfg_ldn == 8'h09 && cfg_index == 8'h61)
            base_r[7:0] <= cfg_wdata;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    property p_reset; disable iff (1'b0) srst |=> io_rdata_r == 8'h00 && rc_discharge == 4'hF; endproperty
    a_reset: assert property (p_reset) else $error("state not cleared by reset");
    property p_hit; rd_hit |=> io_rd_hit_r; endproperty
    a_hit: assert property (p_hit) else $error("read at base not answered");
    property p_miss; !rd_hit |=> !io_rd_hit_r && io_rdata_r == 8'h00; endproperty
    a_miss: assert property (p_miss) else $error("read answered without a decode");
    property p_hold; wr_hit |=> rc_discharge == 4'hF; endproperty
    a_hold: assert property (p_hold) else $error("pins not held low during write");
    property p_trail; wr_hit ##1 !wr_hit |=> ##1 rc_discharge == 4'h0; endproperty
    a_trail: assert property (p_trail) else $error("timers not started after write");
    // Restart wins over the comparator, so the two edges after a write are left out
    property p_cmp; !io_wr_strobe && !$past(io_wr_strobe) && !$past(io_wr_strobe, 2)
        |=> (rc_discharge & $past(rc_cmp_in)) == $past(rc_cmp_in); endproperty
    a_cmp: assert property (p_cmp) else $error("tripped axis not discharged");
    property p_pwr; cfg_wr && cfg_index == 8'h22 |=> stick_active_r == $past(cfg_wdata[2]); endproperty
    a_pwr: assert property (p_pwr) else $error("power bit write lost");
    property p_act; cfg_wr && cfg_ldn == 8'h09 && cfg_index == 8'h30 |=> stick_active_r == $past(cfg_wdata[0]);
    endproperty
    a_act: assert property (p_act) else $error("activate bit write lost");
endmodule : dual_joystick_port_asserts
bind dual_joystick_port dual_joystick_port_asserts i_dual_joystick_port_asserts (.ref_clk, .srst, .io_addr,
    .io_rd_strobe, .io_wr_strobe, .io_rdata_r, .io_rd_hit_r, .cfg_ldn, .cfg_index, .cfg_wdata, .cfg_wr,
    .rc_cmp_in, .rc_discharge, .stick_active_r);

// *** tb/host_io_model.sv ***
`timescale 1ns/1ns
module host_io_model (
    input  wire logic        ref_clk,
    input  wire logic [7:0]  io_rdata_r,
    output logic      [15:0] io_addr,
    output logic             io_rd_strobe,
    output logic             io_wr_strobe
);
    initial begin
        io_addr = 16'hFFFF;
        io_rd_strobe = 1'b0;
        io_wr_strobe = 1'b0;
    end
    // Restart by a byte write, then poll by reads; elapsed time gives position
    task automatic cycle(input logic wr, input logic [15:0] a, input int len, output logic [7:0] d);
        @(negedge ref_clk);
        io_addr = a;
        io_wr_strobe = wr;
        io_rd_strobe = !wr;
        @(negedge ref_clk);
        d = io_rdata_r;
        repeat (len - 1) @(negedge ref_clk);
        io_rd_strobe = 1'b0;
        io_wr_strobe = 1'b0;
        // Released address is not left at the last value
        io_addr = ~a;
    endtask : cycle
endmodule : host_io_model

// *** tb/dual_joystick_port_tb_top.sv ***
`timescale 1ns/1ns
module dual_joystick_port_tb_top;
    logic        ref_clk = 1'b0;
    logic        srst = 1'b1;
    logic [15:0] io_addr;
    logic        io_rd_strobe, io_wr_strobe, io_rd_hit_r, cfg_rd_hit_r, stick_active_r;
    logic        cfg_wr = 1'b0, cfg_rd = 1'b0;
    logic [7:0]  io_rdata_r, cfg_rdata_r, d;
    logic [7:0]  cfg_ldn = 8'h09, cfg_index = 8'h00, cfg_wdata = 8'h00;
    logic [3:0]  btn = 4'h0, rc_cmp_in = 4'h0, rc_discharge;
    int          n_fail = 0, n_tests = 0;
    always #5 ref_clk = ~ref_clk;
    dual_joystick_port i_dual_joystick_port (.ref_clk, .srst, .io_addr, .io_rd_strobe, .io_wr_strobe,
        .io_rdata_r, .io_rd_hit_r, .cfg_ldn, .cfg_index, .cfg_wdata, .cfg_wr, .cfg_rd, .cfg_rdata_r,
        .cfg_rd_hit_r, .stick1_button1(btn[0]), .stick1_button2(btn[1]), .stick2_button1(btn[2]),
        .stick2_button2(btn[3]), .rc_cmp_in, .rc_discharge, .stick_active_r);
    host_io_model i_host_io_model (.ref_clk, .io_rdata_r, .io_addr, .io_rd_strobe, .io_wr_strobe);
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic cfg(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        @(negedge ref_clk);
        cfg_index = idx;
        cfg_wdata = wd;
        cfg_wr = wr;
        cfg_rd = !wr;
        @(negedge ref_clk);
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        d = cfg_rdata_r;
    endtask : cfg
    task automatic t_config;
        check(io_rdata_r, 8'h00);
        i_host_io_model.cycle(1'b0, 16'h0000, 1, d);
        check(d, 8'h00);
        cfg(1'b1, 8'h60, 8'h12);
        cfg(1'b1, 8'h61, 8'h34);
        cfg(1'b1, 8'h30, 8'h01);
        cfg(1'b0, 8'h60, 8'h00);
        check(d, 8'h12);
        check({7'h00, cfg_rd_hit_r}, 8'h01);
        cfg(1'b0, 8'h22, 8'h00);
        check(d, 8'h04);
        cfg(1'b1, 8'h22, 8'h00);
        cfg(1'b0, 8'h30, 8'h00);
        check(d, 8'h00);
        i_host_io_model.cycle(1'b1, 16'h1234, 3, d);
        repeat (3) @(negedge ref_clk);
        check({4'h0, rc_discharge}, 8'h0F);
        cfg(1'b1, 8'h22, 8'h04);
        cfg(1'b0, 8'h30, 8'h00);
        check(d, 8'h01);
    endtask : t_config
    task automatic t_measure;
        int i;
        btn = 4'h5;
        i_host_io_model.cycle(1'b0, 16'h1234, 1, d);
        check(d, 8'h50);
        check({7'h00, io_rd_hit_r}, 8'h01);
        i_host_io_model.cycle(1'b0, 16'h1235, 1, d);
        check(d, 8'h00);
        check({7'h00, io_rd_hit_r}, 8'h00);
        i_host_io_model.cycle(1'b1, 16'h1234, 3, d);
        check({4'h0, rc_discharge}, 8'h0F);
        @(negedge ref_clk);
        check({4'h0, rc_discharge}, 8'h0F);
        @(negedge ref_clk);
        check({4'h0, rc_discharge}, 8'h00);
        i_host_io_model.cycle(1'b0, 16'h1234, 1, d);
        check(d, 8'h5F);
        // Write while timing: only the hold keeps the pins low here
        i_host_io_model.cycle(1'b1, 16'h1234, 2, d);
        check({4'h0, rc_discharge}, 8'h0F);
        i_host_io_model.cycle(1'b0, 16'h1234, 1, d);
        check(d, 8'h5F);
        check({4'h0, rc_discharge}, 8'h00);
        for (i = 0; i < 4; i++) begin
            rc_cmp_in[i] = 1'b1;
            i_host_io_model.cycle(1'b0, 16'h1234, 1, d);
            check(d, {4'h5, 4'hF << (i + 1)});
            check({4'h0, rc_discharge}, {4'h0, 4'hF >> (3 - i)});
        end
    endtask : t_measure
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : complete_run
    initial begin
        repeat (8) @(negedge ref_clk);
        srst = 1'b0;
        t_config;
        t_measure;
        complete_run;
    end
    initial begin
        repeat (100000) @(posedge ref_clk);
        n_fail++;
        complete_run;
    end
endmodule : dual_joystick_port_tb_top
